// ---- hdl/pcv_controller.sv ----
// Purpose: Master end: generates pulse trains and drives enable on the link.
// Assumes: Software writes a level code and command through a plain port.
// Notes: Pulses run at 250 kHz with equal high and low halves.
`timescale 1ns/100ps
module pcv_controller #(
   parameter int unsigned HALF_PULSE_CYC = pcv_pkg::HALF_PULSE_CYC,
   parameter int unsigned IDLE_STOP_CYC = pcv_pkg::IDLE_STOP_CYC,
   parameter int unsigned START_HIGH_CYC = pcv_pkg::START_HIGH_CYC
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Software port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Link
   pcv_link_if.ctrl link
);
   localparam logic [1:0] ADDR_CTRL = pcv_pkg::ADDR_CTRL;
   localparam logic [1:0] ADDR_LEVEL = pcv_pkg::ADDR_LEVEL;
   localparam logic [1:0] ADDR_STATUS = pcv_pkg::ADDR_STATUS;

   initial
   begin
      if (HALF_PULSE_CYC < 1 || HALF_PULSE_CYC >= 65535 || IDLE_STOP_CYC >= 65534 ||
          START_HIGH_CYC < 1 || START_HIGH_CYC >= 65535)
      begin
         $error("pcv_controller: timing parameters out of range");
      end
   end

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_START = 5'h02,
      S_LOW = 5'h04,
      S_HIGH = 5'h08,
      S_STOP = 5'h10
   } pcv_ctrl_fsm_t;

   typedef struct packed {
      pcv_ctrl_fsm_t fsm;
      logic [15:0] tmr;
      logic [5:0] left;
      logic [5:0] level;
      logic en;
      logic wire_hi;
      logic [7:0] rdata;
   } pcv_ctrl_state_t;

   pcv_ctrl_state_t st_reg, st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.rdata = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_CTRL: st_next.rdata = {6'h00, st_reg.wire_hi, st_reg.en};
            ADDR_LEVEL: st_next.rdata = {2'h0, st_reg.level};
            ADDR_STATUS: st_next.rdata = {7'h00, st_reg.fsm != S_IDLE};
            default: st_next.rdata = 8'h00;
         endcase
      end
      if (st_reg.tmr != 16'h0000)
      begin
         st_next.tmr = st_reg.tmr - 16'h0001;
      end
      case (st_reg.fsm)
         S_IDLE:
         begin
            if (reg_wr && reg_addr == ADDR_CTRL)
            begin
               st_next.en = reg_wdata[pcv_pkg::CTRL_EN_BIT];
               st_next.wire_hi = reg_wdata[pcv_pkg::CTRL_WIRE_BIT];
               if (reg_wdata[pcv_pkg::CTRL_SEND_BIT] && st_reg.level >= pcv_pkg::LEVEL_MIN)
               begin
                  st_next.en = 1'b0;
                  st_next.wire_hi = 1'b1;
                  st_next.left = st_reg.level;
                  st_next.tmr = 16'(START_HIGH_CYC);
                  st_next.fsm = S_START;
               end
            end
            else if (reg_wr && reg_addr == ADDR_LEVEL)
            begin
               st_next.level = (reg_wdata[5:0] > pcv_pkg::LEVEL_MAX) ?
                  pcv_pkg::LEVEL_MAX : reg_wdata[5:0];
            end
         end
         S_START:
         begin
            if (st_reg.tmr == 16'h0000)
            begin
               st_next.wire_hi = 1'b0;
               st_next.tmr = 16'(HALF_PULSE_CYC - 1);
               st_next.fsm = S_LOW;
            end
         end
         S_LOW:
         begin
            if (st_reg.tmr == 16'h0000)
            begin
               st_next.wire_hi = 1'b1;
               st_next.left = st_reg.left - 6'h01;
               st_next.tmr = 16'(HALF_PULSE_CYC - 1);
               st_next.fsm = S_HIGH;
            end
         end
         S_HIGH:
         begin
            if (st_reg.tmr == 16'h0000)
            begin
               if (st_reg.left == 6'h00)
               begin
                  st_next.tmr = 16'(IDLE_STOP_CYC + 2);
                  st_next.fsm = S_STOP;
               end
               else
               begin
                  st_next.wire_hi = 1'b0;
                  st_next.tmr = 16'(HALF_PULSE_CYC - 1);
                  st_next.fsm = S_LOW;
               end
            end
         end
         S_STOP:
         begin
            if (st_reg.tmr == 16'h0000)
            begin
               st_next.fsm = S_IDLE;
            end
         end
         default: st_next.fsm = S_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         st_reg <= '0;
         st_reg.fsm <= S_IDLE;
         st_reg.level <= pcv_pkg::LEVEL_DEFAULT;
      end
      else if (clk_en)
      begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign link.enable_pin = st_reg.en;
   assign link.pulse_program_wire = st_reg.wire_hi;
endmodule

// ---- hdl/pcv_device.sv ----
// Purpose: Device end: filters the wire, counts pulses, selects the level.
// Assumes: Wire and enable are synchronous to ref_clk; master honours pulse rate.
// Notes: Fast discharge starts at the enable falling edge with the wire low or at any power-down, when discharge_select_pin is low.
// Function
// - Master alone drives; device never answers.
// - Frames have start and stop conditions.
// - Master keeps pulses at most 250 kHz.
// - Filter glitches on wire falling edges.
// - No shared clock; pulses self-timed.
// - Count pulses live as they arrive.
// - Count N selects level, 1 most negative.
// - Enable high applies default level sixteen.
// - Enable low: wire low off, high programmed.
// - On state from enable and wire together.
// - Master holds enable low while programming.
// - Discharge pin low: discharge after shutdown.
// - Discharge pin high: never discharge.
// - Shutdown starts at enable falling edge.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module pcv_device #(
   parameter int unsigned GLITCH_CYC = pcv_pkg::GLITCH_CYC,
   parameter int unsigned IDLE_STOP_CYC = pcv_pkg::IDLE_STOP_CYC
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Link
   pcv_link_if.dev link,
   // Converter control
   input wire logic discharge_select_pin,
   output logic converter_on,
   output logic [5:0] negative_output_level,
   output logic fast_discharge,
   output logic frame_done
);
   // The filter and idle counters are 16 bits wide.
   if (GLITCH_CYC < 1 || GLITCH_CYC >= 65535)
   begin
      $error("pcv_device: glitch filter length out of range");
   end
   if (IDLE_STOP_CYC >= 65535)
   begin
      $error("pcv_device: idle stop time out of range");
   end
   // A stop time no longer than the filter would end frames inside a pulse.
   if (IDLE_STOP_CYC <= GLITCH_CYC)
   begin
      $error("pcv_device: idle stop time must exceed the filter");
   end

   typedef struct packed {
      logic wire_f;
      logic [15:0] low_cnt;
      logic [15:0] high_cnt;
      logic [15:0] off_cnt;
      logic armed;
      logic in_frame;
      logic [6:0] count;
      logic [5:0] prog_level;
      logic en_d;
      logic on;
      logic [5:0] level;
      logic dis;
      logic done;
   } pcv_dev_state_t;

   pcv_dev_state_t st_reg, st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.done = 1'b0;
      st_next.en_d = link.enable_pin;
      // own clock times pulses.
      // Rises pass unfiltered, so a pulse high is seen at once.
      // glitch filter: a fall counts only after it holds low long enough.
      if (link.pulse_program_wire)
      begin
         st_next.wire_f = 1'b1;
         st_next.low_cnt = 16'h0000;
      end
      else if (st_reg.wire_f)
      begin
         if (st_reg.low_cnt >= 16'(GLITCH_CYC - 1))
         begin
            st_next.wire_f = 1'b0;
            st_next.low_cnt = 16'h0000;
         end
         else
         begin
            st_next.low_cnt = st_reg.low_cnt + 16'h0001;
         end
      end
      // start: filtered high with enable low arms the frame.
      if (st_reg.wire_f && !st_reg.en_d && !link.enable_pin)
      begin
         st_next.armed = 1'b1;
      end
      // live count: each filtered falling edge adds one at once.
      if (st_reg.wire_f && !st_next.wire_f && !link.enable_pin && st_reg.armed)
      begin
         st_next.in_frame = 1'b1;
         if (st_reg.count < 7'h7f)
         begin
            st_next.count = st_reg.count + 7'h01;
         end
      end
      // stop: long filtered high ends the frame, latch with clamp.
      if (st_reg.wire_f && st_next.wire_f)
      begin
         if (st_reg.high_cnt < 16'hffff)
         begin
            st_next.high_cnt = st_reg.high_cnt + 16'h0001;
         end
         if (st_reg.in_frame && st_reg.high_cnt >= 16'(IDLE_STOP_CYC - 1))
         begin
            st_next.in_frame = 1'b0;
            st_next.count = 7'h00;
            st_next.done = 1'b1;
            if (st_reg.count > {1'b0, pcv_pkg::LEVEL_MAX})
            begin
               st_next.prog_level = pcv_pkg::LEVEL_MAX;
            end
            else
            begin
               st_next.prog_level = st_reg.count[5:0];
            end
         end
      end
      else
      begin
         st_next.high_cnt = 16'h0000;
      end
      // long off time: drop frame, restore default.
      if (!st_next.wire_f && !link.enable_pin)
      begin
         if (st_reg.off_cnt < 16'hffff)
         begin
            st_next.off_cnt = st_reg.off_cnt + 16'h0001;
         end
         if (st_reg.off_cnt >= 16'(IDLE_STOP_CYC - 1))
         begin
            st_next.in_frame = 1'b0;
            st_next.count = 7'h00;
            st_next.prog_level = pcv_pkg::LEVEL_RESET;
         end
      end
      else
      begin
         st_next.off_cnt = 16'h0000;
      end
      if (link.enable_pin)
      begin
         st_next.on = 1'b1;
         st_next.level = pcv_pkg::LEVEL_DEFAULT;
         st_next.armed = 1'b0;
         st_next.in_frame = 1'b0;
         st_next.count = 7'h00;
      end
      else
      begin
         // wire low means off, high runs programmed level.
         st_next.on = st_next.wire_f;
         st_next.level = st_reg.prog_level;
      end
      // A pulse low is also an off time, so discharge can blink while programming.
      // Hold the select pin high during a frame where that matters.
      // enable falling edge shuts down; pick discharge.
      if (st_reg.en_d && !link.enable_pin && !st_next.on)
      begin
         st_next.dis = !discharge_select_pin;
      end
      else if (st_next.on || discharge_select_pin)
      begin
         st_next.dis = 1'b0;
      end
      else if (!st_next.on && st_reg.on)
      begin
         st_next.dis = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         st_reg <= '0;
         st_reg.wire_f <= 1'b0;
         st_reg.prog_level <= pcv_pkg::LEVEL_RESET;
         st_reg.level <= pcv_pkg::LEVEL_RESET;
      end
      else if (clk_en)
      begin
         st_reg <= st_next;
      end
   end

   assign converter_on = st_reg.on;
   assign negative_output_level = st_reg.level;
   assign fast_discharge = st_reg.dis;
   assign frame_done = st_reg.done;
endmodule

// ---- shared/pcv_link_if.sv ----
// Purpose: One-direction pulse wire plus enable between controller and device.
// Assumes: Both ends share ref_clk; the controller alone drives both signals.
// Notes: No signal runs from device to controller.
`timescale 1ns/100ps
interface pcv_link_if;
   logic pulse_program_wire;
   logic enable_pin;
   modport ctrl (output pulse_program_wire, output enable_pin);
   modport dev (input pulse_program_wire, input enable_pin);
endinterface

// ---- shared/pcv_pkg.sv ----
// Purpose: Shared constants for the pulse count voltage programmer link.
// Assumes: One 50 MHz clock on both ends; the wire is sampled synchronously.
// Notes: Level codes are pulse counts 1..41; code 1 is the most negative level.
package pcv_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   // Wire timing: pulse rate in hertz, times in nanoseconds.
   localparam int unsigned PULSE_MAX_HZ = 250000;
   localparam int unsigned PULSE_PERIOD_NS = 4000;
   localparam int unsigned GLITCH_NS = 200;
   localparam int unsigned IDLE_STOP_NS = 100000;
   localparam int unsigned START_HIGH_NS = 20000;
   // Cycle counts derived from the times above.
   localparam int unsigned HALF_PULSE_CYC = (PULSE_PERIOD_NS / 2) * (CLK_HZ / 1000000) / 1000;
   localparam int unsigned GLITCH_CYC = GLITCH_NS * (CLK_HZ / 1000000) / 1000;
   localparam int unsigned IDLE_STOP_CYC = IDLE_STOP_NS * (CLK_HZ / 1000000) / 1000;
   localparam int unsigned START_HIGH_CYC = START_HIGH_NS * (CLK_HZ / 1000000) / 1000;
   localparam int unsigned TIMER_W = 16;
   // Level codes.
   localparam int unsigned LEVEL_W = 6;
   localparam logic [5:0] LEVEL_MIN = 6'h01;
   localparam logic [5:0] LEVEL_MAX = 6'h29;
   localparam logic [5:0] LEVEL_DEFAULT = 6'h10;
   localparam logic [5:0] LEVEL_RESET = 6'h10;
   // Controller register offsets and control bit positions.
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_LEVEL = 2'h1;
   localparam logic [1:0] ADDR_STATUS = 2'h2;
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_WIRE_BIT = 1;
   localparam int unsigned CTRL_SEND_BIT = 2;
endpackage

// ---- tb/pcv_properties.sv ----
// Purpose: Concurrent checks on the link and the device outputs.
// Assumes: One clock; reset_n synchronous, active low.
// Notes: The wire and enable are watched as plain inputs.
`timescale 1ns/100ps
module pcv_properties (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Link and device pins
   input wire logic pulse_program_wire,
   input wire logic enable_pin,
   input wire logic discharge_select_pin,
   input wire logic converter_on,
   input wire logic [5:0] negative_output_level,
   input wire logic fast_discharge,
   input wire logic frame_done
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   a_en_default: assert property (enable_pin |=> negative_output_level == 6'h10)
      else $error("level not default under enable");
   a_on_enable: assert property (enable_pin |=> converter_on)
      else $error("device off under enable");
   a_off_both_low: assert property ((!enable_pin && !pulse_program_wire) [*6] |=> !converter_on)
      else $error("device on with both low");
   a_no_discharge: assert property (discharge_select_pin |=> !fast_discharge)
      else $error("discharge while deselected");
   a_discharge_fall: assert property ($fell(enable_pin) && !pulse_program_wire
      && !discharge_select_pin |-> ##[1:2] fast_discharge)
      else $error("no discharge after enable fall");
   a_discharge_on: assert property (converter_on && $past(converter_on) |-> !fast_discharge)
      else $error("discharge while running");
   a_done_single: assert property (frame_done |=> !frame_done)
      else $error("frame done longer than a cycle");
   a_done_idle: assert property (frame_done |-> $past(pulse_program_wire) && !$past(enable_pin))
      else $error("frame done without idle wire");
   a_level_range: assert property (negative_output_level >= 6'h01 && negative_output_level <= 6'h29)
      else $error("level code out of range");
   a_pulse_high: assert property ($rose(pulse_program_wire) && !enable_pin
      |=> pulse_program_wire [*8])
      else $error("wire high half too short");
   c_frame: cover property (frame_done);
   c_discharge: cover property (fast_discharge);
   c_enabled: cover property (enable_pin && converter_on);
endmodule

// ---- tb/tb.sv ----
// Purpose: Self-checking bench joining controller and device over the link.
// Assumes: Shortened wire timings; the half pulse outlasts the glitch filter.
// Notes: Register strobes are one cycle, driven just after the rising edge.
`timescale 1ns/100ps
module tb;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] reg_rdata;
   logic discharge_select_pin = 1'b0;
   logic converter_on;
   logic [5:0] negative_output_level;
   logic fast_discharge;
   logic frame_done;
   logic off_seen = 1'b0;
   int mismatches = 0;
   int n_compared = 0;
   pcv_link_if link ();
   pcv_controller #(.HALF_PULSE_CYC(10), .IDLE_STOP_CYC(50), .START_HIGH_CYC(20)) pcv_controller_inst (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));
   pcv_device #(.GLITCH_CYC(4), .IDLE_STOP_CYC(50)) pcv_device_inst (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .link(link),
      .discharge_select_pin(discharge_select_pin), .converter_on(converter_on),
      .negative_output_level(negative_output_level), .fast_discharge(fast_discharge),
      .frame_done(frame_done));
   pcv_properties pcv_properties_inst (
      .ref_clk(ref_clk), .reset_n(reset_n), .pulse_program_wire(link.pulse_program_wire),
      .enable_pin(link.enable_pin), .discharge_select_pin(discharge_select_pin),
      .converter_on(converter_on), .negative_output_level(negative_output_level),
      .fast_discharge(fast_discharge), .frame_done(frame_done));
   initial
   begin
      forever #10 ref_clk = ~ref_clk;
   end
   // A short wire low must never switch the device off.
   always @(negedge ref_clk)
   begin
      if (converter_on !== 1'b1)
         off_seen = 1'b1;
   end
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task test_done();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk("rdata", reg_rdata, e);
   endtask
   task cycles(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Writes are refused while a frame is in flight, so poll busy first.
   task wait_idle();
      int i;
      for (i = 0; i < 200; i++)
      begin
         @(posedge ref_clk);
         reg_addr <= 2'h2;
         reg_rd <= 1'b1;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         #1;
         if (reg_rdata === 8'h00)
            break;
      end
      if (i == 200)
      begin
         mismatches++;
         test_done();
      end
      chk("busy", reg_rdata, 8'h00);
   endtask
   task t_reset();
      cycles(1);
      chk("level", {2'h0, negative_output_level}, 8'h10);
      chk("on", {7'h00, converter_on}, 8'h00);
      chk("dis", {7'h00, fast_discharge}, 8'h00);
      rd(2'h1, 8'h10);
      rd(2'h3, 8'h00);
      $display("test reset done");
   endtask
   task t_send(input logic [7:0] code, input logic [7:0] e);
      int i;
      wr(2'h1, code);
      rd(2'h1, e);
      wr(2'h0, 8'h04);
      rd(2'h2, 8'h01);
      wr(2'h1, 8'h05);
      for (i = 0; i < 3000 && frame_done !== 1'b1; i++)
         cycles(1);
      if (i == 3000)
      begin
         mismatches++;
         test_done();
      end
      cycles(1);
      chk("level", {2'h0, negative_output_level}, e);
      chk("on", {7'h00, converter_on}, 8'h01);
      chk("en", {7'h00, link.enable_pin}, 8'h00);
      rd(2'h1, e);
      wait_idle();
      $display("test send %0d done", code);
   endtask
   task t_glitch();
      off_seen = 1'b0;
      wr(2'h0, 8'h00);
      wr(2'h0, 8'h02);
      cycles(8);
      chk("glitch", {7'h00, off_seen}, 8'h00);
      wr(2'h0, 8'h00);
      cycles(8);
      chk("on", {7'h00, converter_on}, 8'h00);
      chk("dis", {7'h00, fast_discharge}, 8'h01);
      discharge_select_pin <= 1'b1;
      cycles(3);
      chk("dis", {7'h00, fast_discharge}, 8'h00);
      // A long off time is a power-off and must bring back the default code.
      cycles(60);
      wr(2'h0, 8'h02);
      cycles(10);
      chk("level", {2'h0, negative_output_level}, 8'h10);
      chk("on", {7'h00, converter_on}, 8'h01);
      $display("test glitch done");
   endtask
   task t_enable();
      wr(2'h0, 8'h01);
      cycles(3);
      chk("on", {7'h00, converter_on}, 8'h01);
      chk("level", {2'h0, negative_output_level}, 8'h10);
      // While frozen, a write must be lost and no state may move.
      clk_en <= 1'b0;
      wr(2'h0, 8'h00);
      clk_en <= 1'b1;
      rd(2'h0, 8'h01);
      chk("on", {7'h00, converter_on}, 8'h01);
      discharge_select_pin <= 1'b0;
      wr(2'h0, 8'h00);
      cycles(3);
      chk("dis", {7'h00, fast_discharge}, 8'h01);
      $display("test enable done");
   endtask
   initial
   begin
      cycles(4);
      reset_n <= 1'b1;
      t_reset();
      t_send(8'h01, 8'h01);
      t_send(8'h3f, 8'h29);
      t_send(8'h22, 8'h22);
      t_glitch();
      t_enable();
      test_done();
   end
endmodule
